// >>> rtl/irq_flag_map.svh
// register offsets, field positions and reset values of the interrupt flag block
`ifndef IRQ_FLAG_MAP_SVH
`define IRQ_FLAG_MAP_SVH
// byte offsets on the register bus
`define OFS_EXT_CTRL    6'h00
`define OFS_FLAGS_ONE   6'h04
`define OFS_FLAGS_TWO   6'h08
`define OFS_FLAGS_THREE 6'h0c
`define OFS_ENABLES     6'h10
`define OFS_PRIORITIES  6'h14
`define OFS_GLOBAL_CTRL 6'h18
// external pin control fields
`define EXT_B_PRIO 7
`define EXT_A_PRIO 6
`define EXT_B_EN   4
`define EXT_A_EN   3
`define EXT_B_FLAG 1
`define EXT_A_FLAG 0
// first flag register fields
`define F1_CONV 6
`define F1_RX   5
`define F1_TX   4
`define F1_SSP  3
`define F1_CC1  2
`define F1_TM2  1
`define F1_TM1  0
// second flag register fields
`define F2_OSC 7
`define F2_NVW 4
`define F2_LVD 2
`define F2_CC2 0
// third flag register fields
`define F3_PWM 4
`define F3_CP3 3
`define F3_CP2 2
`define F3_CP1 1
`define F3_TM5 0
// global control fields
`define GC_HIGH_EN  0
`define GC_LOW_EN   1
`define GC_PRIO_EN  7
`define GC_POST_LSB 8
`define GC_POST_MSB 11
// implemented and software-writable bits
`define EXT_CTRL_MASK 8'hdb
`define F1_WMASK      8'h4f
`define F1_RMASK      8'h7f
`define F2_MASK       8'h95
`define F3_MASK       8'h1f
`define PER_MASK      24'h1f957f
`define GC_MASK       12'hf83
// reset values
`define EXT_CTRL_RST 8'hc0
`define PRIO_RST     24'h1f957f
// vectors and bus responses
`define VEC_HIGH   24'h000008
`define VEC_LOW    24'h000018
`define RESP_OKAY  2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/irq_flag_pkg.sv
// types of the interrupt flag block
package irq_flag_pkg;
  `include "irq_flag_map.svh"
  // whole state of the block, registered as one word
  typedef struct packed {
    logic        aw_held;
    logic [5:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ext_ctrl;
    logic [7:0]  peripheral_flags_one;
    logic [7:0]  peripheral_flags_two;
    logic [7:0]  peripheral_flags_three;
    logic [23:0] enables;
    logic [23:0] priorities;
    logic [11:0] gctrl;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  prev;
    logic [3:0]  post_cnt;
    logic        irq_high;
    logic        irq_low;
    logic [23:0] vector;
  } state_s;
endpackage

// >>> rtl/interrupt_flag_registers.sv
// interrupt flag, enable and priority registers with an axi4-lite slave
//
// Notes on behaviour
// - bits 7/6 give pin b/a priority
// - bits 4/3 enable pin b/a interrupts
// - bits 1/0 latch pin b/a events
// - unimplemented bits always read zero
// - flags set regardless of any interrupt enable
// - conversion done sets sticky flag
// - receive flag mirrors full buffer, read-only
// - transmit flag mirrors empty buffer, read-only
// - sync serial completion sets sticky flag
// - capture/compare events set flags, not pwm
// - timer two match sets sticky flag
// - timer one overflow sets sticky flag
// - oscillator failure sets sticky flag
// - nonvolatile write completion sets flag
// - low supply sets sticky flag
// - postscaled pwm period match sets flag
// - capture three or direction change sets
// - capture two or limit/index sets
// - capture one or velocity edge sets
// - timer five match sets sticky flag
// - compat mode needs peripheral group enable
// - priority mode bit defaults off
// - high vector 08h, low vector 18h
// - compat mode ignores priorities, one vector
`timescale 1ns/1ps
`include "irq_flag_map.svh"
module interrupt_flag_registers
  import irq_flag_pkg::*;
#(
  parameter int ADDR_W = 6              // register bus address width
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_pin_a,
  input  wire logic              ext_pin_b,
  input  wire logic              conversion_done,
  input  wire logic              serial_rx_full,
  input  wire logic              serial_tx_empty,
  input  wire logic              sync_serial_done,
  input  wire logic              capcmp_one_event,
  input  wire logic              capcmp_one_pwm_mode,
  input  wire logic              capcmp_two_event,
  input  wire logic              capcmp_two_pwm_mode,
  input  wire logic              timer_two_match,
  input  wire logic              timer_one_overflow,
  input  wire logic              osc_fail_to_internal_oscillator,
  input  wire logic              nv_write_done,
  input  wire logic              low_voltage_detect,
  input  wire logic              pwm_period_match,
  input  wire logic              capture_three_enable,
  input  wire logic              capture_three_event,
  input  wire logic              direction_change,
  input  wire logic              capture_two_event,
  input  wire logic              position_count_limit_hit,
  input  wire logic              index_pulse_input,
  input  wire logic              capture_one_event,
  input  wire logic              velocity_edge,
  input  wire logic              timer_five_match,
  input  wire logic              velocity_mode_select,
  input  wire logic              capture_one_timer_reset_enable,
  input  wire logic [2:0]        decoder_mode_field,
  output logic                   irq_high,
  output logic                   irq_low,
  output logic [23:0]            irq_vector
);

  // reset image: priorities default high, priority mode off
  localparam state_s ST_RST = '{ext_ctrl: `EXT_CTRL_RST, priorities: `PRIO_RST, default: '0};

  state_s      st_r;                    // registered state
  state_s      st_nxt;                  // next state
  logic        do_write;                // address and data both held
  logic        ar_take;                 // read address accepted
  logic [1:0]  pin_edge;                // rising edges of synchronised pins
  logic        dec_on;                  // quadrature decoder enabled
  logic [7:0]  set1;                    // set pulses, first flag register
  logic [7:0]  set2;                    // set pulses, second flag register
  logic [7:0]  set3;                    // set pulses, third flag register
  logic        pwm_hit;                 // postscaled pwm period match
  logic [23:0] per_pend;                // enabled peripheral requests
  logic [1:0]  ext_pend;                // enabled pin requests
  logic        any_hi;                  // a high-priority request waits
  logic        any_lo;                  // a low-priority request waits

  // byte-lane merge of a write into a 32-bit word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // register read view; bit 32 flags an unmapped address
  function automatic logic [32:0] reg_read(input logic [5:0] a, input state_s s, input logic rx, input logic tx);
    logic [32:0] r;
    r = '0;
    case ({a[5:2], 2'h0})
      `OFS_EXT_CTRL:    r[7:0] = s.ext_ctrl & `EXT_CTRL_MASK;
      `OFS_FLAGS_ONE:   r[7:0] = (s.peripheral_flags_one & `F1_WMASK) | ({7'h00, rx} << `F1_RX)
                                 | ({7'h00, tx} << `F1_TX);
      `OFS_FLAGS_TWO:   r[7:0] = s.peripheral_flags_two & `F2_MASK;
      `OFS_FLAGS_THREE: r[7:0] = s.peripheral_flags_three & `F3_MASK;
      `OFS_ENABLES:     r[23:0] = s.enables;
      `OFS_PRIORITIES:  r[23:0] = s.priorities;
      `OFS_GLOBAL_CTRL: r[11:0] = s.gctrl;
      default:          r[32] = 1'b1;   // unmapped: slave error, zero data
    endcase
    return r;
  endfunction

  // handshake outputs come straight from the holding state
  assign s_axi_awready = !st_r.aw_held;
  assign s_axi_wready  = !st_r.w_held;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign irq_high      = st_r.irq_high;
  assign irq_low       = st_r.irq_low;
  assign irq_vector    = st_r.vector;

  assign do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign ar_take  = s_axi_arvalid && !st_r.rvalid;
  // edge detect compares the second synchroniser stage with its copy from the cycle before
  assign pin_edge = st_r.sync2 & ~st_r.prev;
  assign dec_on   = |decoder_mode_field;
  // postscaler: flag only on every (n+1)th period match
  assign pwm_hit  = pwm_period_match && (st_r.post_cnt == st_r.gctrl[`GC_POST_MSB:`GC_POST_LSB]);

  // flag set sources; no interrupt enable bit is looked at, only capture_three_enable and capture_one_timer_reset_enable
  always_comb begin
    set1 = '0;
    set2 = '0;
    set3 = '0;
    set1[`F1_CONV] = conversion_done;
    set1[`F1_SSP]  = sync_serial_done;
    set1[`F1_CC1]  = capcmp_one_event && !capcmp_one_pwm_mode;
    set1[`F1_TM2]  = timer_two_match;
    set1[`F1_TM1]  = timer_one_overflow;
    set2[`F2_OSC]  = osc_fail_to_internal_oscillator;
    set2[`F2_NVW]  = nv_write_done;
    set2[`F2_LVD]  = low_voltage_detect;
    set2[`F2_CC2]  = capcmp_two_event && !capcmp_two_pwm_mode;
    set3[`F3_PWM]  = pwm_hit;
    // capture inputs give way to the decoder when it is on
    set3[`F3_CP3]  = dec_on ? direction_change : (capture_three_enable && capture_three_event);
    set3[`F3_CP2]  = dec_on ? (decoder_mode_field[2] ? position_count_limit_hit : index_pulse_input)
                            : capture_two_event;
    set3[`F3_CP1]  = dec_on ? (!velocity_mode_select && capture_one_timer_reset_enable && velocity_edge)
                            : capture_one_event;
    set3[`F3_TM5]  = timer_five_match;
  end

  // request gating and vector choice
  always_comb begin
    per_pend = {st_r.peripheral_flags_three, st_r.peripheral_flags_two, st_r.peripheral_flags_one | ({7'h00, serial_rx_full} << `F1_RX)
               | ({7'h00, serial_tx_empty} << `F1_TX)} & st_r.enables & `PER_MASK;
    ext_pend = {st_r.ext_ctrl[`EXT_B_FLAG] & st_r.ext_ctrl[`EXT_B_EN],
                st_r.ext_ctrl[`EXT_A_FLAG] & st_r.ext_ctrl[`EXT_A_EN]};
    if (st_r.gctrl[`GC_PRIO_EN]) begin
      // priority mode: each source goes to the level its priority bit picks
      any_hi = st_r.gctrl[`GC_HIGH_EN] && ((|(per_pend & st_r.priorities))
               || (ext_pend[1] && st_r.ext_ctrl[`EXT_B_PRIO])
               || (ext_pend[0] && st_r.ext_ctrl[`EXT_A_PRIO]));
      any_lo = st_r.gctrl[`GC_LOW_EN] && ((|(per_pend & ~st_r.priorities))
               || (ext_pend[1] && !st_r.ext_ctrl[`EXT_B_PRIO])
               || (ext_pend[0] && !st_r.ext_ctrl[`EXT_A_PRIO]));
    end else begin
      // compatibility: priorities ignored, peripherals also need the group enable
      any_hi = st_r.gctrl[`GC_HIGH_EN] && ((|ext_pend)
               || (st_r.gctrl[`GC_LOW_EN] && (|per_pend)));
      any_lo = 1'b0;
    end
  end

  // next-state logic: bus slave, flags, synchronisers
  always_comb begin
    logic [32:0] rd;
    logic [31:0] wv;
    rd     = '0;
    wv     = '0;
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.sync1 = {ext_pin_b, ext_pin_a};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    // write channels are taken independently
    if (s_axi_awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr[5:0];
    end
    if (s_axi_wvalid && !st_r.w_held) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // apply a write once both halves are held and no response is waiting
    if (do_write) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = `RESP_OKAY;
      case ({st_r.aw_addr[5:2], 2'h0})
        `OFS_EXT_CTRL: begin
          wv = lane_merge({24'h0, st_r.ext_ctrl}, st_r.w_data, st_r.w_strb);
          st_nxt.ext_ctrl = wv[7:0] & `EXT_CTRL_MASK;
        end
        `OFS_FLAGS_ONE: begin
          // receive and transmit bits are never stored
          wv = lane_merge({24'h0, st_r.peripheral_flags_one}, st_r.w_data, st_r.w_strb);
          st_nxt.peripheral_flags_one = wv[7:0] & `F1_WMASK;
        end
        `OFS_FLAGS_TWO: begin
          wv = lane_merge({24'h0, st_r.peripheral_flags_two}, st_r.w_data, st_r.w_strb);
          st_nxt.peripheral_flags_two = wv[7:0] & `F2_MASK;
        end
        `OFS_FLAGS_THREE: begin
          wv = lane_merge({24'h0, st_r.peripheral_flags_three}, st_r.w_data, st_r.w_strb);
          st_nxt.peripheral_flags_three = wv[7:0] & `F3_MASK;
        end
        `OFS_ENABLES: begin
          wv = lane_merge({8'h0, st_r.enables}, st_r.w_data, st_r.w_strb);
          st_nxt.enables = wv[23:0] & `PER_MASK;
        end
        `OFS_PRIORITIES: begin
          wv = lane_merge({8'h0, st_r.priorities}, st_r.w_data, st_r.w_strb);
          st_nxt.priorities = wv[23:0] & `PER_MASK;
        end
        `OFS_GLOBAL_CTRL: begin
          wv = lane_merge({20'h0, st_r.gctrl}, st_r.w_data, st_r.w_strb);
          st_nxt.gctrl = wv[11:0] & `GC_MASK;
        end
        default: begin
          st_nxt.bresp = `RESP_SLVERR;   // unmapped: nothing stored
        end
      endcase
    end
    // hardware sets are applied after the software value, so a set beats a clear
    st_nxt.ext_ctrl[`EXT_A_FLAG] = st_nxt.ext_ctrl[`EXT_A_FLAG] | pin_edge[0];
    st_nxt.ext_ctrl[`EXT_B_FLAG] = st_nxt.ext_ctrl[`EXT_B_FLAG] | pin_edge[1];
    st_nxt.peripheral_flags_one = st_nxt.peripheral_flags_one | set1;
    st_nxt.peripheral_flags_two = st_nxt.peripheral_flags_two | set2;
    st_nxt.peripheral_flags_three = st_nxt.peripheral_flags_three | set3;
    // postscale counter advances on each period match
    if (pwm_period_match) begin
      st_nxt.post_cnt = pwm_hit ? 4'h0 : st_r.post_cnt + 4'h1;
    end
    // read channel: one read in flight, answered the next cycle
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      rd = reg_read(s_axi_araddr[5:0], st_r, serial_rx_full, serial_tx_empty);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd[31:0];
      st_nxt.rresp  = rd[32] ? `RESP_SLVERR : `RESP_OKAY;
    end
    // core request outputs; high beats low on the vector
    st_nxt.irq_high = any_hi;
    st_nxt.irq_low  = any_lo && !any_hi;
    st_nxt.vector   = (any_lo && !any_hi) ? `VEC_LOW : `VEC_HIGH;
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // software must clear a stale flag itself before enabling its source

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [1:0] ext_req;                  // enabled pin requests, for checks
  assign ext_req = ext_pend;

  property p_reserved_zero;
    st_r.ext_ctrl[5] == 1'b0 && st_r.ext_ctrl[2] == 1'b0 && st_r.peripheral_flags_three[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unimplemented bit set");

  property p_pin_flag;
    pin_edge[0] |=> st_r.ext_ctrl[`EXT_A_FLAG] [*2];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin a flag not latched");

  property p_set_regardless;
    (osc_fail_to_internal_oscillator && !st_r.enables[8 + `F2_OSC] && !st_r.gctrl[`GC_HIGH_EN]) |=> st_r.peripheral_flags_two[`F2_OSC];
  endproperty
  a_set_regardless: assert property (p_set_regardless) else $error("flag blocked by enable");

  property p_set_beats_clear;
    (conversion_done && do_write && st_r.aw_addr[5:2] == 4'h1) |=> st_r.peripheral_flags_one[`F1_CONV];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear won over set");

  property p_rx_mirror;
    (ar_take && s_axi_araddr[5:2] == 4'h1) |=> s_axi_rdata[`F1_RX] == $past(serial_rx_full);
  endproperty
  a_rx_mirror: assert property (p_rx_mirror) else $error("receive flag readback wrong");

  property p_ro_not_stored;
    do_write |=> st_r.peripheral_flags_one[`F1_RX] == 1'b0 && st_r.peripheral_flags_one[`F1_TX] == 1'b0;
  endproperty
  a_ro_not_stored: assert property (p_ro_not_stored) else $error("read-only flag stored");

  property p_compat_no_low;
    !st_r.gctrl[`GC_PRIO_EN] |=> !irq_low;
  endproperty
  a_compat_no_low: assert property (p_compat_no_low) else $error("low request in compat mode");

  property p_group_gate;
    (!st_r.gctrl[`GC_PRIO_EN] && !st_r.gctrl[`GC_LOW_EN] && ext_req == 2'h0) |=> !irq_high;
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("peripheral passed group gate");

  property p_vector_low;
    irq_low |-> irq_vector == `VEC_LOW && !irq_high;
  endproperty
  a_vector_low: assert property (p_vector_low) else $error("low vector wrong");

  property p_unmapped_read;
    (ar_take && s_axi_araddr[5:2] > 4'h6) |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

  c_irq_high: cover property (irq_high);
  c_irq_low: cover property (irq_low);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_pwm_flag: cover property (pwm_hit);

endmodule // interrupt_flag_registers

// >>> verification/periph_model.sv
// peripheral stand-in: turns each bench request into one event strobe
`timescale 1ns/1ps
module periph_model
  import irq_flag_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [17:0] fire,
  output logic      [17:0] ev
);
  logic [17:0] fire_r;  // request level seen at the last edge

  // remember the request so a held request strobes only once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fire_r <= '0;
    end else begin
      fire_r <= fire;
    end
  end

  // a peripheral reports completion as a single-cycle strobe, never a level
  assign ev = fire & ~fire_r;
endmodule // periph_model

// >>> verification/interrupt_flag_registers_tb.sv
// self-checking bench of the interrupt flag registers
`timescale 1ns/1ps
`include "irq_flag_map.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module interrupt_flag_registers_tb
  import irq_flag_pkg::*;
;
  logic        aclk = 1'b0;     // 125 mhz system clock
  logic        aresetn = 1'b0;  // synchronous reset, active low
  logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;  // whole words only
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, ext_pin_a = 1'b0, ext_pin_b = 1'b0, serial_rx_full = 1'b0;
  logic        serial_tx_empty = 1'b0, capcmp_one_pwm_mode = 1'b0, capcmp_two_pwm_mode = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_high, irq_low;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] irq_vector;
  logic        capture_three_enable = 1'b1, velocity_mode_select = 1'b0, capture_one_timer_reset_enable = 1'b0;
  logic [2:0]  decoder_mode_field = 3'h0;  // decoder off until the decoder scenario
  logic [17:0] fire = '0;  // event requests to the peripheral model
  wire  [17:0] ev;         // event strobes from the peripheral model
  int          miscompares = 0;
  int          tests_run = 0;
  // upper nibble register index, lower nibble flag bit, in the order of fire
  localparam logic [7:0] EV_MAP [14] = '{8'h16, 8'h13, 8'h12, 8'h11, 8'h10, 8'h27, 8'h24, 8'h22, 8'h20,
                                         8'h34, 8'h33, 8'h32, 8'h31, 8'h30};

  // capture and decoder controls come from the bench, so every decoder source is reached
  interrupt_flag_registers dut (.*, .conversion_done(ev[0]), .sync_serial_done(ev[1]), .capcmp_one_event(ev[2]),
    .timer_two_match(ev[3]), .timer_one_overflow(ev[4]), .osc_fail_to_internal_oscillator(ev[5]),
    .nv_write_done(ev[6]), .low_voltage_detect(ev[7]), .capcmp_two_event(ev[8]), .pwm_period_match(ev[9]),
    .capture_three_event(ev[10]), .capture_two_event(ev[11]), .capture_one_event(ev[12]),
    .timer_five_match(ev[13]), .direction_change(ev[14]), .position_count_limit_hit(ev[15]),
    .index_pulse_input(ev[16]), .velocity_edge(ev[17]));
  periph_model partner (.aclk(aclk), .aresetn(aresetn), .fire(fire), .ev(ev));

  // clock generator
  initial begin
    forever #4 aclk = ~aclk;
  end

  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] exp_r);
    logic aw_p;
    logic w_p;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, exp_r)
    s_axi_bready <= 1'b0;
  endtask

  // bus read and compare of data and response
  task automatic rd(input logic [5:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    `CHK(s_axi_rdata, exp_d)
    `CHK(s_axi_rresp, exp_r)
    s_axi_rready <= 1'b0;
  endtask

  // reset values and the unmapped hole
  task automatic t_reset;
    rd(`OFS_EXT_CTRL, 32'hc0, `RESP_OKAY);
    rd(`OFS_FLAGS_TWO, 32'h0, `RESP_OKAY);
    rd(`OFS_GLOBAL_CTRL, 32'h0, `RESP_OKAY);
    rd(6'h1c, 32'h0, `RESP_SLVERR);
    wr(6'h1c, 32'hffffffff, `RESP_SLVERR);
  endtask

  // all ones written: unimplemented positions must stay zero
  task automatic t_ext;
    wr(`OFS_EXT_CTRL, 32'hffffffff, `RESP_OKAY);
    rd(`OFS_EXT_CTRL, 32'hdb, `RESP_OKAY);
    wr(`OFS_FLAGS_THREE, 32'hffffffff, `RESP_OKAY);
    rd(`OFS_FLAGS_THREE, 32'h1f, `RESP_OKAY);
    wr(`OFS_FLAGS_THREE, 32'h0, `RESP_OKAY);
    wr(`OFS_EXT_CTRL, 32'h0, `RESP_OKAY);
    rd(`OFS_EXT_CTRL, 32'h0, `RESP_OKAY);
  endtask

  // pin edges latch with every enable off; flags stick after the pin falls
  task automatic t_pins;
    ext_pin_a <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(`OFS_EXT_CTRL, 32'h01, `RESP_OKAY);
    ext_pin_a <= 1'b0;
    ext_pin_b <= 1'b1;
    repeat (5) @(posedge aclk);
    ext_pin_b <= 1'b0;
    rd(`OFS_EXT_CTRL, 32'h03, `RESP_OKAY);
    wr(`OFS_EXT_CTRL, 32'h0, `RESP_OKAY);
    rd(`OFS_EXT_CTRL, 32'h0, `RESP_OKAY);
  endtask

  // each of the 14 non-decoder event sources sets its own flag alone, then software clears it
  task automatic t_events;
    for (int i = 0; i < 14; i++) begin
      fire[i] <= 1'b1;
      repeat (2) @(posedge aclk);
      fire[i] <= 1'b0;
      rd({EV_MAP[i][7:4], 2'b00}, 32'h1 << EV_MAP[i][2:0], `RESP_OKAY);
      wr({EV_MAP[i][7:4], 2'b00}, 32'h0, `RESP_OKAY);
      rd({EV_MAP[i][7:4], 2'b00}, 32'h0, `RESP_OKAY);
    end
  endtask

  // one-cycle request to the peripheral model, released before the next call
  task automatic pulse(input logic [17:0] f);
    fire <= f;
    @(posedge aclk);
    fire <= '0;
    @(posedge aclk);
  endtask

  // a completion in the very cycle a software clear lands keeps the flag set
  task automatic t_race;
    fork
      wr(`OFS_FLAGS_ONE, 32'h0, `RESP_OKAY);
      begin
        repeat (2) @(posedge aclk);
        pulse(18'h00001);
      end
    join
    rd(`OFS_FLAGS_ONE, 32'h40, `RESP_OKAY);
    wr(`OFS_FLAGS_ONE, 32'h0, `RESP_OKAY);
  endtask

  // decoder sources replace the captures while the decoder is on
  task automatic t_decoder;
    capture_three_enable <= 1'b0;
    pulse(18'h00400);
    rd(`OFS_FLAGS_THREE, 32'h0, `RESP_OKAY);
    decoder_mode_field <= 3'h4;
    pulse(18'h31c00);
    rd(`OFS_FLAGS_THREE, 32'h0, `RESP_OKAY);
    capture_one_timer_reset_enable <= 1'b1;
    pulse(18'h2c000);
    rd(`OFS_FLAGS_THREE, 32'h0e, `RESP_OKAY);
    wr(`OFS_FLAGS_THREE, 32'h0, `RESP_OKAY);
    decoder_mode_field <= 3'h1;
    velocity_mode_select <= 1'b1;
    pulse(18'h38000);
    rd(`OFS_FLAGS_THREE, 32'h04, `RESP_OKAY);
    wr(`OFS_FLAGS_THREE, 32'h0, `RESP_OKAY);
    decoder_mode_field <= 3'h0;
    capture_three_enable <= 1'b1;
  endtask

  // capture/compare events are ignored in pwm mode
  task automatic t_pwm_mode;
    capcmp_one_pwm_mode <= 1'b1;
    capcmp_two_pwm_mode <= 1'b1;
    fire <= 18'h00104;
    repeat (2) @(posedge aclk);
    fire <= '0;
    rd(`OFS_FLAGS_ONE, 32'h0, `RESP_OKAY);
    rd(`OFS_FLAGS_TWO, 32'h0, `RESP_OKAY);
    capcmp_one_pwm_mode <= 1'b0;
    capcmp_two_pwm_mode <= 1'b0;
  endtask

  // serial flags follow the buffers and shrug off software writes
  task automatic t_serial;
    serial_rx_full <= 1'b1;
    serial_tx_empty <= 1'b1;
    rd(`OFS_FLAGS_ONE, 32'h30, `RESP_OKAY);
    wr(`OFS_FLAGS_ONE, 32'h0, `RESP_OKAY);
    rd(`OFS_FLAGS_ONE, 32'h30, `RESP_OKAY);
    serial_rx_full <= 1'b0;
    rd(`OFS_FLAGS_ONE, 32'h10, `RESP_OKAY);
    serial_tx_empty <= 1'b0;
    rd(`OFS_FLAGS_ONE, 32'h0, `RESP_OKAY);
  endtask

  // group gating in compatibility mode, then the low vector in priority mode
  task automatic t_irq;
    wr(`OFS_PRIORITIES, 32'h0, `RESP_OKAY);
    wr(`OFS_ENABLES, 32'h40, `RESP_OKAY);
    fire[0] <= 1'b1;
    repeat (2) @(posedge aclk);
    fire[0] <= 1'b0;
    wr(`OFS_GLOBAL_CTRL, 32'h1, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq_high, 1'b0)
    wr(`OFS_GLOBAL_CTRL, 32'h3, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq_high, 1'b1)
    `CHK(irq_vector, `VEC_HIGH)
    wr(`OFS_GLOBAL_CTRL, 32'h83, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK({irq_high, irq_low}, 2'b01)
    `CHK(irq_vector, `VEC_LOW)
  endtask

  // verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ext();
    t_pins();
    t_events();
    t_race();
    t_decoder();
    t_pwm_mode();
    t_serial();
    t_irq();
    conclude();
  end
endmodule // interrupt_flag_registers_tb
